/* File: hdl/pfs_map.svh */
// Register map, field positions, codes and reset values of the port A pin function selector.
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// Register width and word indexes (byte address is four times the index).
`define PFS_REG_W 16
`define PFS_IDX_W 6
`define PFS_IDX_PROT 6'h12
`define PFS_IDX_SEL0 6'h13
`define PFS_IDX_SEL1 6'h14
`define PFS_IDX_PEREN 6'h20
`define PFS_IDX_CLOCK_OUTPUT_CTRL 6'h21
`define PFS_IDX_PCE 6'h22
`define PFS_ADR_W 8
`define PFS_ADR_IDX_LSB 2

// Protection field codes and bit meanings.
`define PFS_PROT_OFF 2'h0
`define PFS_PROT_ON 2'h1
`define PFS_PROT_OFF_LOCK 2'h2
`define PFS_PROT_ON_LOCK 2'h3
`define PFS_PROT_ON_BIT 0
`define PFS_PROT_LOCK_BIT 1
`define PFS_PROT_PSP 0
`define PFS_PROT_CC 1
`define PFS_PROT_N 2

// Select field positions.
`define PFS_SEL0_PA6_BIT 12
`define PFS_SEL0_PA5_LSB 10
`define PFS_SEL0_PA4_LSB 8
`define PFS_SEL1_PA14_LSB 12
`define PFS_SEL1_PA13_LSB 10
`define PFS_SEL1_PA12_LSB 8
`define PFS_SEL1_PA11_BIT 6

// Writable masks; every other bit reads as zero.
`define PFS_MASK_PROT 16'h000F
`define PFS_MASK_SEL0 16'h1F00
`define PFS_MASK_SEL1 16'h3F40
`define PFS_MASK_FULL 16'hFFFF
`define PFS_MASK_CLK_GEN 16'h000F
`define PFS_MASK_CLK_TEST 16'h0030
`define PFS_CLOCK_OUTPUT_CTRL_W 6
`define PFS_RST_VAL 16'h0000

// Function codes of a select field.
`define PFS_FN0 2'h0
`define PFS_FN1 2'h1
`define PFS_FN2 2'h2

// Port A pin numbers that carry peripheral functions here.
`define PFS_PA4 4
`define PFS_PA5 5
`define PFS_PA6 6
`define PFS_PA11 11
`define PFS_PA12 12
`define PFS_PA13 13
`define PFS_PA14 14

`endif

/* File: hdl/pfs_pkg.sv */
// Types shared by the pin function selector modules.
`include "pfs_map.svh"
package pfs_pkg;
    typedef logic [`PFS_REG_W-1:0] pfs_reg_t;
    typedef logic [1:0] pfs_prot_t;

    // State of one protection field.
    typedef struct packed {
        pfs_prot_t field;
    } pfs_prot_s;

    // Whole state of the top module.
    typedef struct packed {
        logic ack;
        pfs_reg_t rdata;
        pfs_reg_t sel0;
        pfs_reg_t sel1;
        pfs_reg_t peren;
        pfs_reg_t pce;
        logic [`PFS_CLOCK_OUTPUT_CTRL_W-1:0] clock_output_ctrl;
        pfs_reg_t pad_out;
        pfs_reg_t pad_oe;
        pfs_reg_t gpio_in;
        logic fault_input_zero;
        logic fault_input_one;
        logic fault_input_two;
        logic cmp_b2;
        logic sp2_din;
        logic sp2_clk;
        logic [3:0] ta_in;
        logic [3:1] tb_in;
    } pfs_state_s;
endpackage

/* File: hdl/pfs_prot_field.sv */
// One two-bit write protection field with its lock.
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_prot_field
    import pfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [1:0] wr_data_i,
    output logic [1:0] field_o
);
    pfs_prot_s st;
    pfs_prot_s next_st;

    // A locked field ignores every write; only reset reopens it.
    always_comb begin
        next_st = st;
        if (wr_i && !st.field[`PFS_PROT_LOCK_BIT]) begin
            next_st.field = wr_data_i;
        end
    end

    // Reset returns the field to unlocked with protection off.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.field <= `PFS_PROT_OFF;
        end else begin
            st <= next_st;
        end
    end

    assign field_o = st.field;
endmodule // pfs_prot_field

/* File: hdl/pfs_top.sv */
// Port A pin function multiplexer with write protection, on a classic Wishbone slave.
// Contract
// - Clock-control protection codes: off, on, off locked, on locked; guards clock regs. Here it guards only the clock enable register.
// - Pin-select protection uses same codes; guards select, enable, mode, drive registers. Here there are no mode or drive registers to guard.
// - A locked protection field ignores writes until chip reset restores off, unlocked.
// - An unlocked protection field may toggle between off and on freely.
// - Pin-select protection also guards the test PWM bits of clock output control.
// - Peripheral enable clear gives GPIO; set lets the select field choose peripheral.
// - Each peripheral input comes from whichever pin is currently assigned to it.
// - Shared function: output fans to all assigned pins, inputs are combined.
// - After reset every pin acts as GPIO.
// - Pin 6 bit 12 of select 0: clear fault zero, set timer A channel 0.
// - Pin 5 bits 11-10: PWM five, fault two, timer A channel 3, reserved.
// - Pin 4 bits 9-8: PWM four, fault one, timer A channel 2, reserved.
// - Pin 14 bits 13-12: timer B ch3, serial data out, timer A ch3.
// - Pin 13 bits 11-10: timer B ch2, serial data in, timer A ch2.
// - Pin 12 bits 9-8: timer B ch1, serial clock, timer A ch1.
// - Pin 11 bit 6 of select 1: clear comparator B input 2, set timer B3.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_top
    import pfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PFS_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] pad_in_i,
    output logic [15:0] pad_out_o,
    output logic [15:0] pad_oe_o,
    input wire logic [15:0] gpio_out_i,
    input wire logic [15:0] gpio_oe_i,
    output logic [15:0] gpio_in_o,
    input wire logic pwm_output_four_i,
    input wire logic pwm_output_five_i,
    input wire logic [3:0] timer_a_out_i,
    input wire logic [3:0] timer_a_oe_i,
    output logic [3:0] timer_a_in_o,
    input wire logic [3:1] timer_b_out_i,
    input wire logic [3:1] timer_b_oe_i,
    output logic [3:1] timer_b_in_o,
    input wire logic serial_port2_data_out_i,
    input wire logic serial_port2_clock_out_i,
    input wire logic serial_port2_clock_oe_i,
    output logic serial_port2_data_in_o,
    output logic serial_port2_clock_in_o,
    output logic fault_input_zero_o,
    output logic fault_input_one_o,
    output logic fault_input_two_o,
    output logic comparator_b_input2_o,
    output logic [15:0] pin_periph_enable_o,
    output logic [15:0] periph_clock_enable_o,
    output logic [`PFS_CLOCK_OUTPUT_CTRL_W-1:0] clock_output_ctrl_o,
    output logic [1:0] pin_select_protect_o,
    output logic [1:0] clock_ctrl_protect_o
);
    pfs_state_s st;
    pfs_state_s next_st;
    logic take;
    logic wr;
    logic [`PFS_IDX_W-1:0] idx;
    logic psp_on;
    logic cc_on;
    logic [1:0] prot_field [`PFS_PROT_N];
    logic [1:0] fn_pa4;
    logic [1:0] fn_pa5;
    logic [1:0] fn_pa6;
    logic [1:0] fn_pa11;
    logic [1:0] fn_pa12;
    logic [1:0] fn_pa13;
    logic [1:0] fn_pa14;
    pfs_reg_t clk_merge;

    // Merge the enabled byte lanes of write data into a register under a mask.
    function automatic pfs_reg_t wb_merge(input pfs_reg_t old, input logic [31:0] wd,
                                          input logic [3:0] sel, input pfs_reg_t mask);
        pfs_reg_t lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        return (old & ~lane) | (wd[`PFS_REG_W-1:0] & lane);
    endfunction

    // True when a pin is handed to peripherals and its select field holds a code.
    function automatic logic fn_hit(input logic en, input logic [1:0] field,
                                    input logic [1:0] code);
        return en && (field == code);
    endfunction

    // Bus request is taken once; the registered ack drops in the following cycle.
    assign take = wb_cyc_i && wb_stb_i && !st.ack;
    assign wr = take && wb_we_i;
    assign idx = wb_adr_i[`PFS_ADR_W-1:`PFS_ADR_IDX_LSB];

    // Active protection is bit zero of each field, whether locked or not.
    assign psp_on = prot_field[`PFS_PROT_PSP][`PFS_PROT_ON_BIT];
    assign cc_on = prot_field[`PFS_PROT_CC][`PFS_PROT_ON_BIT];

    // Clock output merge; the test bits leave the mask while pin-select guard is on.
    assign clk_merge = wb_merge({10'h000, st.clock_output_ctrl}, wb_dat_i, wb_sel_i,
        psp_on ? `PFS_MASK_CLK_GEN : (`PFS_MASK_CLK_GEN | `PFS_MASK_CLK_TEST));

    // Select codes per pin; one-bit fields are widened so one decoder serves all.
    assign fn_pa4 = st.sel0[`PFS_SEL0_PA4_LSB +: 2];
    assign fn_pa5 = st.sel0[`PFS_SEL0_PA5_LSB +: 2];
    assign fn_pa6 = {1'b0, st.sel0[`PFS_SEL0_PA6_BIT]};
    assign fn_pa11 = {1'b0, st.sel1[`PFS_SEL1_PA11_BIT]};
    assign fn_pa12 = st.sel1[`PFS_SEL1_PA12_LSB +: 2];
    assign fn_pa13 = st.sel1[`PFS_SEL1_PA13_LSB +: 2];
    assign fn_pa14 = st.sel1[`PFS_SEL1_PA14_LSB +: 2];

    // Each protection field has its own locking cell, two bits apart in the register.
    for (genvar g = 0; g < `PFS_PROT_N; g++) begin : g_prot
        pfs_prot_field u_field (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_i(wr && (idx == `PFS_IDX_PROT) && wb_sel_i[0]),
            .wr_data_i(wb_dat_i[2*g +: 2]),
            .field_o(prot_field[g])
        );
    end

    // Next state: bus registers, read data, pad drive and peripheral inputs.
    always_comb begin
        next_st = st;
        next_st.ack = take;
        next_st.rdata = `PFS_RST_VAL;
        // Reads return only implemented bits so reserved bits stay zero.
        if (take && !wb_we_i) begin
            case (idx)
                `PFS_IDX_PROT: next_st.rdata = {12'h000, prot_field[`PFS_PROT_CC],
                                                prot_field[`PFS_PROT_PSP]};
                `PFS_IDX_SEL0: next_st.rdata = st.sel0 & `PFS_MASK_SEL0;
                `PFS_IDX_SEL1: next_st.rdata = st.sel1 & `PFS_MASK_SEL1;
                `PFS_IDX_PEREN: next_st.rdata = st.peren;
                `PFS_IDX_CLOCK_OUTPUT_CTRL: next_st.rdata = {10'h000, st.clock_output_ctrl};
                `PFS_IDX_PCE: next_st.rdata = st.pce;
                default: next_st.rdata = `PFS_RST_VAL;
            endcase
        end
        // Guarded writes are dropped silently while their protection is on.
        if (wr) begin
            case (idx)
                `PFS_IDX_SEL0: begin
                    if (!psp_on) begin
                        next_st.sel0 = wb_merge(st.sel0, wb_dat_i, wb_sel_i, `PFS_MASK_SEL0);
                    end
                end
                `PFS_IDX_SEL1: begin
                    if (!psp_on) begin
                        next_st.sel1 = wb_merge(st.sel1, wb_dat_i, wb_sel_i, `PFS_MASK_SEL1);
                    end
                end
                `PFS_IDX_PEREN: begin
                    if (!psp_on) begin
                        next_st.peren = wb_merge(st.peren, wb_dat_i, wb_sel_i, `PFS_MASK_FULL);
                    end
                end
                `PFS_IDX_PCE: begin
                    if (!cc_on) begin
                        next_st.pce = wb_merge(st.pce, wb_dat_i, wb_sel_i, `PFS_MASK_FULL);
                    end
                end
                `PFS_IDX_CLOCK_OUTPUT_CTRL: begin
                    // General bits stay writable; the test bits follow pin-select guard.
                    next_st.clock_output_ctrl = clk_merge[`PFS_CLOCK_OUTPUT_CTRL_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Pins with enable clear follow GPIO; enabled pins start undriven until a function claims them.
        next_st.gpio_in = pad_in_i;
        for (int i = 0; i < `PFS_REG_W; i++) begin
            if (!st.peren[i]) begin
                next_st.pad_out[i] = gpio_out_i[i];
                next_st.pad_oe[i] = gpio_oe_i[i];
            end else begin
                next_st.pad_out[i] = 1'b0;
                next_st.pad_oe[i] = 1'b0;
            end
        end
        // Output side: a peripheral drives every pin that selects it.
        if (fn_hit(st.peren[`PFS_PA4], fn_pa4, `PFS_FN0)) begin
            next_st.pad_out[`PFS_PA4] = pwm_output_four_i;
            next_st.pad_oe[`PFS_PA4] = 1'b1;
        end else if (fn_hit(st.peren[`PFS_PA4], fn_pa4, `PFS_FN2)) begin
            next_st.pad_out[`PFS_PA4] = timer_a_out_i[2];
            next_st.pad_oe[`PFS_PA4] = timer_a_oe_i[2];
        end
        if (fn_hit(st.peren[`PFS_PA5], fn_pa5, `PFS_FN0)) begin
            next_st.pad_out[`PFS_PA5] = pwm_output_five_i;
            next_st.pad_oe[`PFS_PA5] = 1'b1;
        end else if (fn_hit(st.peren[`PFS_PA5], fn_pa5, `PFS_FN2)) begin
            next_st.pad_out[`PFS_PA5] = timer_a_out_i[3];
            next_st.pad_oe[`PFS_PA5] = timer_a_oe_i[3];
        end
        if (fn_hit(st.peren[`PFS_PA6], fn_pa6, `PFS_FN1)) begin
            next_st.pad_out[`PFS_PA6] = timer_a_out_i[0];
            next_st.pad_oe[`PFS_PA6] = timer_a_oe_i[0];
        end
        if (fn_hit(st.peren[`PFS_PA11], fn_pa11, `PFS_FN1)) begin
            next_st.pad_out[`PFS_PA11] = timer_b_out_i[3];
            next_st.pad_oe[`PFS_PA11] = timer_b_oe_i[3];
        end
        if (fn_hit(st.peren[`PFS_PA12], fn_pa12, `PFS_FN0)) begin
            next_st.pad_out[`PFS_PA12] = timer_b_out_i[1];
            next_st.pad_oe[`PFS_PA12] = timer_b_oe_i[1];
        end else if (fn_hit(st.peren[`PFS_PA12], fn_pa12, `PFS_FN1)) begin
            next_st.pad_out[`PFS_PA12] = serial_port2_clock_out_i;
            next_st.pad_oe[`PFS_PA12] = serial_port2_clock_oe_i;
        end else if (fn_hit(st.peren[`PFS_PA12], fn_pa12, `PFS_FN2)) begin
            next_st.pad_out[`PFS_PA12] = timer_a_out_i[1];
            next_st.pad_oe[`PFS_PA12] = timer_a_oe_i[1];
        end
        if (fn_hit(st.peren[`PFS_PA13], fn_pa13, `PFS_FN0)) begin
            next_st.pad_out[`PFS_PA13] = timer_b_out_i[2];
            next_st.pad_oe[`PFS_PA13] = timer_b_oe_i[2];
        end else if (fn_hit(st.peren[`PFS_PA13], fn_pa13, `PFS_FN2)) begin
            next_st.pad_out[`PFS_PA13] = timer_a_out_i[2];
            next_st.pad_oe[`PFS_PA13] = timer_a_oe_i[2];
        end
        if (fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN0)) begin
            next_st.pad_out[`PFS_PA14] = timer_b_out_i[3];
            next_st.pad_oe[`PFS_PA14] = timer_b_oe_i[3];
        end else if (fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN1)) begin
            next_st.pad_out[`PFS_PA14] = serial_port2_data_out_i;
            next_st.pad_oe[`PFS_PA14] = 1'b1;
        end else if (fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN2)) begin
            next_st.pad_out[`PFS_PA14] = timer_a_out_i[3];
            next_st.pad_oe[`PFS_PA14] = timer_a_oe_i[3];
        end
        // Input side: OR of all assigned pins, zero when no pin is assigned.
        next_st.fault_input_zero = fn_hit(st.peren[`PFS_PA6], fn_pa6, `PFS_FN0)
                         && pad_in_i[`PFS_PA6];
        next_st.fault_input_one = fn_hit(st.peren[`PFS_PA4], fn_pa4, `PFS_FN1)
                         && pad_in_i[`PFS_PA4];
        next_st.fault_input_two = fn_hit(st.peren[`PFS_PA5], fn_pa5, `PFS_FN1)
                         && pad_in_i[`PFS_PA5];
        next_st.cmp_b2 = fn_hit(st.peren[`PFS_PA11], fn_pa11, `PFS_FN0)
                         && pad_in_i[`PFS_PA11];
        next_st.sp2_din = fn_hit(st.peren[`PFS_PA13], fn_pa13, `PFS_FN1)
                          && pad_in_i[`PFS_PA13];
        next_st.sp2_clk = fn_hit(st.peren[`PFS_PA12], fn_pa12, `PFS_FN1)
                          && pad_in_i[`PFS_PA12];
        next_st.ta_in[0] = fn_hit(st.peren[`PFS_PA6], fn_pa6, `PFS_FN1)
                           && pad_in_i[`PFS_PA6];
        next_st.ta_in[1] = fn_hit(st.peren[`PFS_PA12], fn_pa12, `PFS_FN2)
                           && pad_in_i[`PFS_PA12];
        next_st.ta_in[2] = (fn_hit(st.peren[`PFS_PA4], fn_pa4, `PFS_FN2) && pad_in_i[`PFS_PA4])
            || (fn_hit(st.peren[`PFS_PA13], fn_pa13, `PFS_FN2) && pad_in_i[`PFS_PA13]);
        next_st.ta_in[3] = (fn_hit(st.peren[`PFS_PA5], fn_pa5, `PFS_FN2) && pad_in_i[`PFS_PA5])
            || (fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN2) && pad_in_i[`PFS_PA14]);
        next_st.tb_in[1] = fn_hit(st.peren[`PFS_PA12], fn_pa12, `PFS_FN0)
                           && pad_in_i[`PFS_PA12];
        next_st.tb_in[2] = fn_hit(st.peren[`PFS_PA13], fn_pa13, `PFS_FN0)
                           && pad_in_i[`PFS_PA13];
        next_st.tb_in[3] = (fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN0)
                            && pad_in_i[`PFS_PA14])
            || (fn_hit(st.peren[`PFS_PA11], fn_pa11, `PFS_FN1) && pad_in_i[`PFS_PA11]);
    end

    // Reset clears every field, so all pins come up as GPIO with default selects.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops; one cycle of latency on every path.
    assign wb_dat_o = {16'h0000, st.rdata};
    assign wb_ack_o = st.ack;
    assign pad_out_o = st.pad_out;
    assign pad_oe_o = st.pad_oe;
    assign gpio_in_o = st.gpio_in;
    assign timer_a_in_o = st.ta_in;
    assign timer_b_in_o = st.tb_in;
    assign serial_port2_data_in_o = st.sp2_din;
    assign serial_port2_clock_in_o = st.sp2_clk;
    assign fault_input_zero_o = st.fault_input_zero;
    assign fault_input_one_o = st.fault_input_one;
    assign fault_input_two_o = st.fault_input_two;
    assign comparator_b_input2_o = st.cmp_b2;
    assign pin_periph_enable_o = st.peren;
    assign periph_clock_enable_o = st.pce;
    assign clock_output_ctrl_o = st.clock_output_ctrl;
    assign pin_select_protect_o = prot_field[`PFS_PROT_PSP];
    assign clock_ctrl_protect_o = prot_field[`PFS_PROT_CC];

    // Checks on the protection, routing and bus behaviour.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    psp_lock_hold_a: assert property (pin_select_protect_o[1] |=> $stable(pin_select_protect_o))
        else $error("locked pin-select protection changed");
    cc_lock_hold_a: assert property (clock_ctrl_protect_o[1] |=> $stable(clock_ctrl_protect_o))
        else $error("locked clock-control protection changed");
    prot_toggle_a: assert property (wr && idx == `PFS_IDX_PROT && wb_sel_i[0]
        && !pin_select_protect_o[1] |=> pin_select_protect_o == $past(wb_dat_i[1:0]))
        else $error("unlocked protection field did not take the write");
    sel_guard_a: assert property (wr && psp_on && (idx == `PFS_IDX_SEL0
        || idx == `PFS_IDX_SEL1 || idx == `PFS_IDX_PEREN)
        |=> $stable(st.sel0) && $stable(st.sel1) && $stable(pin_periph_enable_o))
        else $error("guarded select register changed");
    clk_guard_a: assert property (wr && cc_on && idx == `PFS_IDX_PCE
        |=> $stable(periph_clock_enable_o))
        else $error("guarded clock enable register changed");
    test_guard_a: assert property (wr && psp_on && idx == `PFS_IDX_CLOCK_OUTPUT_CTRL
        |=> $stable(clock_output_ctrl_o[5:4]))
        else $error("guarded test bits changed");
    gpio_route_a: assert property (!pin_periph_enable_o[`PFS_PA6]
        |=> pad_out_o[`PFS_PA6] == $past(gpio_out_i[`PFS_PA6]))
        else $error("GPIO pin not driven by GPIO");
    fault_input_zero_route_a: assert property (pin_periph_enable_o[`PFS_PA6] && !st.sel0[12]
        |=> fault_input_zero_o == $past(pad_in_i[`PFS_PA6]) && !pad_oe_o[`PFS_PA6])
        else $error("fault zero not routed from pin 6");
    shared_input_a: assert property (fn_hit(st.peren[`PFS_PA5], fn_pa5, `PFS_FN2)
        && fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN2) && pad_in_i[`PFS_PA14]
        |=> timer_a_in_o[3])
        else $error("shared timer input lost a pin");
    reserved_zero_a: assert property (wb_ack_o && $past(idx) == `PFS_IDX_SEL1
        |-> wb_dat_o[31:16] == 16'h0000 && (wb_dat_o[15:0] & ~`PFS_MASK_SEL1) == 16'h0000)
        else $error("reserved bits read nonzero");
    bus_answer_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");

    lock_seen_c: cover property (pin_select_protect_o == `PFS_PROT_ON_LOCK);
    serial_out_c: cover property (fn_hit(st.peren[`PFS_PA14], fn_pa14, `PFS_FN1));
    shared_fn_c: cover property (fn_hit(st.peren[`PFS_PA4], fn_pa4, `PFS_FN2)
        && fn_hit(st.peren[`PFS_PA13], fn_pa13, `PFS_FN2));
    blocked_write_c: cover property (wr && psp_on && idx == `PFS_IDX_SEL1);
endmodule // pfs_top

/* File: tb/pfs_periph_model.sv */
// Partner model: peripheral drives and the pad levels seen by the mux.
`timescale 1ns/1ps
module pfs_periph_model (
    input wire logic [3:0] pat_i,
    input wire logic [15:0] pad_out_i,
    input wire logic [15:0] pad_oe_i,
    input wire logic [15:0] ext_i,
    output logic [15:0] pad_in_o,
    output logic [3:0] ta_o,
    output logic [3:1] tb_o
);
    // A driven pad reads back its drive; an undriven one shows the outside level.
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
    // Timers follow one pattern, so every routed pin carries a known level.
    assign ta_o = pat_i;
    assign tb_o = pat_i[3:1];
endmodule // pfs_periph_model

/* File: tb/tb_top.sv */
// Self-checking bench for the port A pin function selector.
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] pat = 4'h0;
    logic [15:0] gout = 16'h0;
    logic [15:0] goe = 16'h0;
    logic [15:0] ext = 16'h0;
    logic [15:0] q;
    logic [15:0] pin, pout, poe, gin;
    logic [3:0] ta, ta_in;
    logic [3:1] tbo;
    logic [31:0] dout;
    logic ack, f2;
    logic f0, f1, cmp, sdi, sck;
    logic [3:1] tbi;
    logic [15:0] pce, pen;
    logic [5:0] cko;
    logic [1:0] psp, ccp;
    int n_fail = 0;
    int compares = 0;
    int idx [4] = '{8'h4C, 8'h4C, 8'h50, 8'h50};
    logic [15:0] val [4] = '{16'h1000, 16'h0200, 16'h0200, 16'h0800};
    int pno [4] = '{6, 4, 12, 13};
    int chn [4] = '{0, 2, 1, 2};
    // Clock at 250 MHz.
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    pfs_periph_model u_model (.pat_i(pat), .pad_out_i(pout), .pad_oe_i(poe), .ext_i(ext),
        .pad_in_o(pin), .ta_o(ta), .tb_o(tbo));
    pfs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .gpio_out_i(gout), .gpio_oe_i(goe),
        .gpio_in_o(gin), .pwm_output_four_i(pat[1]), .pwm_output_five_i(pat[0]),
        .timer_a_out_i(ta), .timer_a_oe_i(4'hF), .timer_a_in_o(ta_in), .timer_b_out_i(tbo),
        .timer_b_oe_i(3'h7), .timer_b_in_o(tbi), .serial_port2_data_out_i(pat[2]),
        .serial_port2_clock_out_i(pat[3]), .serial_port2_clock_oe_i(1'b1),
        .serial_port2_data_in_o(sdi), .serial_port2_clock_in_o(sck), .fault_input_zero_o(f0),
        .fault_input_one_o(f1), .fault_input_two_o(f2), .comparator_b_input2_o(cmp),
        .pin_periph_enable_o(pen), .periph_clock_enable_o(pce), .clock_output_ctrl_o(cko),
        .pin_select_protect_o(psp), .clock_ctrl_protect_o(ccp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the answer is taken at the edge that samples ack high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_fail++;
            tally_and_finish();
        end
        q = dout[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0);
        chk(q, e);
    endtask
    // Pad paths are one flop deep; two edges leave them settled.
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic t_gpio();
        gout <= 16'hA5C3;
        goe <= 16'hFFFF;
        settle();
        chk(pout, 16'hA5C3);
        chk(gin, 16'hA5C3);
        rdc(8'h4C, 16'h0000);
    endtask
    task automatic t_prot();
        xfer(1'b1, 8'h48, 16'h0001);
        xfer(1'b1, 8'h4C, 16'h1F00);
        rdc(8'h4C, 16'h0000);
        xfer(1'b1, 8'h48, 16'h0000);
        xfer(1'b1, 8'h4C, 16'hFFFF);
        rdc(8'h4C, 16'h1F00);
        xfer(1'b1, 8'h50, 16'hFFFF);
        rdc(8'h50, 16'h3F40);
        xfer(1'b1, 8'h48, 16'h0001);
        rdc(8'h48, 16'h0001);
        xfer(1'b1, 8'h84, 16'h003F);
        rdc(8'h84, 16'h000F);
        chk(cko, 6'h0F);
        xfer(1'b1, 8'h48, 16'hFFFE);
        rdc(8'h48, 16'h000E);
        xfer(1'b1, 8'h48, 16'h0001);
        rdc(8'h48, 16'h000E);
        chk({ccp, psp}, 4'hE);
        xfer(1'b1, 8'h88, 16'hFFFF);
        rdc(8'h88, 16'h0000);
        xfer(1'b1, 8'h4C, 16'h0000);
        rdc(8'h4C, 16'h0000);
        do_reset();
        rdc(8'h48, 16'h0000);
        rdc(8'h90, 16'h0000);
        xfer(1'b1, 8'h88, 16'h1234);
        chk(pce, 16'h1234);
    endtask
    task automatic t_mux();
        pat <= 4'h1;
        xfer(1'b1, 8'h80, 16'h0020);
        settle();
        chk({poe[5], pout[5]}, 2'h3);
        xfer(1'b1, 8'h4C, 16'h0400);
        ext <= 16'h0020;
        settle();
        chk({poe[5], f2}, 2'h1);
        xfer(1'b1, 8'h4C, 16'h0800);
        xfer(1'b1, 8'h50, 16'h2000);
        xfer(1'b1, 8'h80, 16'h4020);
        pat <= 4'h8;
        settle();
        chk({pout[14], pout[5], ta_in[3]}, 3'h7);
        chk(pen, 16'h4020);
        for (int p = 0; p < 2; p++) begin
            pat <= p ? 4'h5 : 4'hA;
            for (int i = 0; i < 4; i++) begin
                xfer(1'b1, 8'h80, 16'h0000);
                xfer(1'b1, idx[i][7:0], val[i]);
                xfer(1'b1, 8'h80, 16'h0001 << pno[i]);
                settle();
                chk(pout[pno[i]], pat[chn[i]]);
            end
        end
    endtask
    // Input routing to the peripherals, then the remaining outputs of select register 1.
    task automatic t_route();
        xfer(1'b1, 8'h4C, 16'h0100);
        xfer(1'b1, 8'h50, 16'h0500);
        xfer(1'b1, 8'h80, 16'h7850);
        pat <= 4'h8;
        ext <= 16'h2850;
        settle();
        chk({f0, f1, cmp, sdi, sck, tbi[3]}, 6'h3F);
        @(posedge clk_i);
        pat <= 4'h0;
        ext <= 16'h0000;
        settle();
        chk({f0, f1, cmp, sdi, sck, tbi[3]}, 6'h00);
        xfer(1'b1, 8'h50, 16'h1040);
        xfer(1'b1, 8'h80, 16'h7800);
        pat <= 4'h4;
        settle();
        chk({pout[14], pout[11], pout[12], pout[13]}, 4'h9);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The whole run needs a few hundred cycles; this limit catches a hang.
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        t_gpio();
        t_prot();
        t_mux();
        t_route();
        tally_and_finish();
    end
endmodule // tb_top
